// ===== inc/swd_pkg.sv
// Shared constants and types for the supervisor watchdog and its host
package swd_pkg;
   // Clock rate
   localparam int CLK_MHZ = 25;

   // Battery supply lockout thresholds in millivolts, with hysteresis
   localparam logic [15:0] UV_ON_MV = 16'h1838;
   localparam logic [15:0] UV_OFF_MV = 16'h1900;
   localparam logic [15:0] OV_ON_MV = 16'h4E20;
   localparam logic [15:0] OV_OFF_MV = 16'h4C2C;

   // Host supply reset thresholds in millivolts
   localparam logic [15:0] HOST_LO_MV = 16'h1068;
   localparam logic [15:0] HOST_HI_MV = 16'h10CC;

   // Watchdog timeout: base plus step per unit of setting
   localparam int WD_BASE_US = 1000;
   localparam int WD_STEP_US = 20000;
   localparam int WD_BASE_CYC = WD_BASE_US * CLK_MHZ;
   localparam int WD_STEP_CYC = WD_STEP_US * CLK_MHZ;
   localparam int WD_CNT_W = 26;
   localparam int WD_SET_W = 6;

   // Reset pulse after a watchdog timeout
   localparam int RST_PULSE_US = 20;
   localparam int RST_PULSE_CYC = RST_PULSE_US * CLK_MHZ;
   localparam int PULSE_CNT_W = 10;

   // Host timing
   localparam int SETTLE_MS = 20;
   localparam int SETTLE_CYC = SETTLE_MS * 1000 * CLK_MHZ;
   localparam int KICK_PERIOD_US = 500;
   localparam int KICK_PERIOD_CYC = KICK_PERIOD_US * CLK_MHZ;
   localparam int HOST_CNT_W = 24;

   // Reset values
   localparam logic LOCK_RST = 1'b1;
   localparam logic SLEEP_N_RST = 1'b1;
   localparam logic [3:0] GATE_OFF = 4'h0;

   // Watchdog states
   typedef enum logic [1:0] {
      WD_RUN = 2'b00,
      WD_PULSE = 2'b01,
      WD_LOCK = 2'b10
   } swd_wd_type;
endpackage

// ===== inc/swd_link_if.sv
// Link between supervisor device and host controller
`timescale 1ns/10ps
interface swd_link_if;
   logic kick;
   logic sleepRequestN;
   logic speedLevel;
   logic directionLevel;
   logic resetDrive;
   logic resetOe;
   logic resetLine;

   // Open-drain reset with pull-up
   assign resetLine = resetOe ? resetDrive : 1'b1;

   modport dev (
      input kick,
      input sleepRequestN,
      input speedLevel,
      input directionLevel,
      input resetLine,
      output resetDrive,
      output resetOe
   );

   modport host (
      output kick,
      output sleepRequestN,
      output speedLevel,
      output directionLevel,
      input resetLine
   );
endinterface

// ===== verilog/swd_device.sv
// Supervisor device: supply lockouts, host reset, watchdog and standby
`timescale 1ns/10ps
module swd_device #(
   parameter int WdBaseCyc = swd_pkg::WD_BASE_CYC,
   parameter int WdStepCyc = swd_pkg::WD_STEP_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Link to host
   swd_link_if.dev link,
   // Supply measurements in millivolts
   input wire logic [15:0] vbatMv,
   input wire logic [15:0] vhostMv,
   // Watchdog timing
   input wire logic [swd_pkg::WD_SET_W-1:0] timeoutSetting,
   input wire logic timeoutCapGrounded,
   // Gate commands from drive logic
   input wire logic [3:0] gateCmd,
   // Gate and pump outputs
   output logic [3:0] gateOut,
   output logic chargePumpRun,
   // Status
   output logic disableState,
   output logic lowSupplyLockout,
   output logic highSupplyLockout,
   output logic hostResetHold,
   output logic wdTimeout,
   output logic standbyActive,
   // Synchronised host levels
   output logic speedLevel,
   output logic directionLevel
);
   localparam int CntW = swd_pkg::WD_CNT_W;
   localparam int PulseW = swd_pkg::PULSE_CNT_W;
   localparam logic [PulseW-1:0] PulseLast = PulseW'(swd_pkg::RST_PULSE_CYC - 1);

   logic kickMeta_r;
   logic kickSync_r;
   logic kickPrev_r;
   logic sleepMeta_r;
   logic sleepSync_r;
   logic capMeta_r;
   logic capSync_r;
   logic speedMeta_r;
   logic speedSync_r;
   logic dirMeta_r;
   logic dirSync_r;
   logic lowLock_r;
   logic highLock_r;
   logic hostHold_r;
   swd_pkg::swd_wd_type wdState_r;
   logic [CntW-1:0] wdCount_r;
   logic [PulseW-1:0] pulseCount_r;
   logic [CntW-1:0] wdLimit;
   logic kickEdge;
   logic disableNow;

   // Pin synchronisers
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         kickMeta_r <= 1'b0;
         kickSync_r <= 1'b0;
         kickPrev_r <= 1'b0;
         sleepMeta_r <= swd_pkg::SLEEP_N_RST;
         sleepSync_r <= swd_pkg::SLEEP_N_RST;
         capMeta_r <= 1'b0;
         capSync_r <= 1'b0;
         speedMeta_r <= 1'b0;
         speedSync_r <= 1'b0;
         dirMeta_r <= 1'b0;
         dirSync_r <= 1'b0;
      end else begin
         kickMeta_r <= link.kick;
         kickSync_r <= kickMeta_r;
         kickPrev_r <= kickSync_r;
         sleepMeta_r <= link.sleepRequestN;
         sleepSync_r <= sleepMeta_r;
         capMeta_r <= timeoutCapGrounded;
         capSync_r <= capMeta_r;
         speedMeta_r <= link.speedLevel;
         speedSync_r <= speedMeta_r;
         dirMeta_r <= link.directionLevel;
         dirSync_r <= dirMeta_r;
      end
   end

   // Either edge of the kick line counts as a kick
   assign kickEdge = kickSync_r ^ kickPrev_r;

   // Timeout limit in cycles
   assign wdLimit = CntW'(WdBaseCyc + WdStepCyc * int'(timeoutSetting));

   // Battery lockouts with hysteresis
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         lowLock_r <= swd_pkg::LOCK_RST;
         highLock_r <= swd_pkg::LOCK_RST;
      end else begin
         if (vbatMv < swd_pkg::UV_ON_MV) begin
            lowLock_r <= 1'b1;
         end else if (vbatMv > swd_pkg::UV_OFF_MV) begin
            lowLock_r <= 1'b0;
         end
         if (vbatMv > swd_pkg::OV_ON_MV) begin
            highLock_r <= 1'b1;
         end else if (vbatMv < swd_pkg::OV_OFF_MV) begin
            highLock_r <= 1'b0;
         end
      end
   end

   // Host supply supervisor, active in every mode
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         hostHold_r <= swd_pkg::LOCK_RST;
      end else if (vhostMv < swd_pkg::HOST_LO_MV) begin
         hostHold_r <= 1'b1;
      end else if (vhostMv > swd_pkg::HOST_HI_MV) begin
         hostHold_r <= 1'b0;
      end
   end

   // Watchdog, independent of standby
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wdState_r <= swd_pkg::WD_RUN;
         wdCount_r <= '0;
         pulseCount_r <= '0;
      end else begin
         case (wdState_r)
            swd_pkg::WD_RUN: begin
               if (capSync_r || hostHold_r || kickEdge) begin
                  wdCount_r <= '0;
               end else if (wdCount_r >= wdLimit) begin
                  wdState_r <= swd_pkg::WD_PULSE;
                  wdCount_r <= '0;
                  pulseCount_r <= '0;
               end else begin
                  wdCount_r <= wdCount_r + 1'b1;
               end
            end
            swd_pkg::WD_PULSE: begin
               if (pulseCount_r == PulseLast) begin
                  wdState_r <= swd_pkg::WD_LOCK;
               end else begin
                  pulseCount_r <= pulseCount_r + 1'b1;
               end
            end
            swd_pkg::WD_LOCK: begin
               if (kickEdge || capSync_r) begin
                  wdState_r <= swd_pkg::WD_RUN;
                  wdCount_r <= '0;
               end
            end
            default: begin
               wdState_r <= swd_pkg::WD_RUN;
               wdCount_r <= '0;
               pulseCount_r <= '0;
            end
         endcase
      end
   end

   // Combined disable cause
   assign disableNow = lowLock_r || highLock_r || hostHold_r
      || (wdState_r != swd_pkg::WD_RUN);

   // Open-drain host reset: drive low only while asserted
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         link.resetDrive <= 1'b0;
         link.resetOe <= 1'b1;
      end else begin
         link.resetDrive <= 1'b0;
         link.resetOe <= hostHold_r || (wdState_r == swd_pkg::WD_PULSE);
      end
   end

   // Gate drivers and charge pump
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         gateOut <= swd_pkg::GATE_OFF;
         chargePumpRun <= 1'b0;
      end else begin
         if (disableNow || !sleepSync_r) begin
            gateOut <= swd_pkg::GATE_OFF;
         end else begin
            gateOut <= gateCmd;
         end
         chargePumpRun <= sleepSync_r;
      end
   end

   // Status outputs
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         disableState <= 1'b1;
         lowSupplyLockout <= swd_pkg::LOCK_RST;
         highSupplyLockout <= swd_pkg::LOCK_RST;
         hostResetHold <= swd_pkg::LOCK_RST;
         wdTimeout <= 1'b0;
         standbyActive <= 1'b0;
         speedLevel <= 1'b0;
         directionLevel <= 1'b0;
      end else begin
         disableState <= disableNow;
         lowSupplyLockout <= lowLock_r;
         highSupplyLockout <= highLock_r;
         hostResetHold <= hostHold_r;
         wdTimeout <= (wdState_r != swd_pkg::WD_RUN);
         standbyActive <= !sleepSync_r;
         speedLevel <= speedSync_r;
         directionLevel <= dirSync_r;
      end
   end
endmodule

// ===== verilog/swd_host.sv
// Host controller end: watchdog kicks, standby request and drive gating
`timescale 1ns/10ps
module swd_host #(
   parameter int KickPeriodCyc = swd_pkg::KICK_PERIOD_CYC,
   parameter int SettleCyc = swd_pkg::SETTLE_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Link to device
   swd_link_if.host link,
   // User requests
   input wire logic kickEnable,
   input wire logic standbyReq,
   input wire logic motorStopped,
   input wire logic speedReq,
   input wire logic directionReq,
   // Status
   output logic hostInReset,
   output logic standbyGranted,
   output logic driveReady
);
   localparam int CW = swd_pkg::HOST_CNT_W;
   localparam logic [CW-1:0] KickLast = CW'(KickPeriodCyc - 1);
   localparam logic [CW-1:0] SettleLoad = CW'(SettleCyc);

   logic rstMeta_r;
   logic rstSync_r;
   logic [CW-1:0] kickCount_r;
   logic [CW-1:0] settleCount_r;
   logic canSleep;

   // Reset line synchroniser
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rstMeta_r <= 1'b0;
         rstSync_r <= 1'b0;
         hostInReset <= 1'b1;
      end else begin
         rstMeta_r <= link.resetLine;
         rstSync_r <= rstMeta_r;
         hostInReset <= !rstSync_r;
      end
   end

   // Periodic kick toggle
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         kickCount_r <= '0;
         link.kick <= 1'b0;
      end else if (!kickEnable || hostInReset) begin
         kickCount_r <= '0;
      end else if (kickCount_r == KickLast) begin
         kickCount_r <= '0;
         link.kick <= !link.kick;
      end else begin
         kickCount_r <= kickCount_r + 1'b1;
      end
   end

   // Standby only with inputs idle and motor stopped
   assign canSleep = standbyReq && motorStopped && !speedReq && !directionReq
      && !link.speedLevel && !link.directionLevel;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         link.sleepRequestN <= swd_pkg::SLEEP_N_RST;
         standbyGranted <= 1'b0;
      end else begin
         if (!standbyReq) begin
            link.sleepRequestN <= 1'b1;
            standbyGranted <= 1'b0;
         end else if (canSleep) begin
            link.sleepRequestN <= 1'b0;
            standbyGranted <= 1'b1;
         end
      end
   end

   // Settle delay after power-up and standby exit
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         settleCount_r <= SettleLoad;
         driveReady <= 1'b0;
      end else begin
         if (!link.sleepRequestN) begin
            settleCount_r <= SettleLoad;
         end else if (settleCount_r != '0) begin
            settleCount_r <= settleCount_r - 1'b1;
         end
         driveReady <= link.sleepRequestN && (settleCount_r == '0);
      end
   end

   // Speed and direction held at zero until ready
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         link.speedLevel <= 1'b0;
         link.directionLevel <= 1'b0;
      end else begin
         link.speedLevel <= driveReady && !standbyReq && speedReq;
         link.directionLevel <= driveReady && !standbyReq && directionReq;
      end
   end
endmodule

// ===== sim/swd_checker.sv
// Link and device status assertions
`timescale 1ns/10ps
module swd_checker #(
   parameter int WdLimit = 60
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Link
   input wire logic kick,
   input wire logic resetDrive,
   input wire logic resetOe,
   input wire logic resetLine,
   // Device status
   input wire logic timeoutCapGrounded,
   input wire logic [3:0] gateOut,
   input wire logic chargePumpRun,
   input wire logic disableState,
   input wire logic wdTimeout,
   input wire logic standbyActive
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   logic [9:0] pulseCnt_r;
   logic [15:0] quietCnt_r;
   logic kickLast_r;
   // Length of the watchdog reset pulse
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) pulseCnt_r <= 10'h000;
      else pulseCnt_r <= (resetOe && wdTimeout) ? pulseCnt_r + 10'h001 : 10'h000;
   end
   // Cycles since the kick line last moved
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         kickLast_r <= 1'b0;
         quietCnt_r <= 16'h0000;
      end else begin
         kickLast_r <= kick;
         quietCnt_r <= (kick != kickLast_r) ? 16'h0000 : quietCnt_r + 16'h0001;
      end
   end
   property p_odLow;
      resetOe |-> !resetLine && !resetDrive;
   endproperty
   a_odLow: assert property (p_odLow) else $error("reset not low");
   property p_odHigh;
      !resetOe |-> resetLine;
   endproperty
   a_odHigh: assert property (p_odHigh) else $error("reset not pulled up");
   property p_pulse;
      wdTimeout && $fell(resetOe) |-> pulseCnt_r == 10'h1F4;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulse length wrong");
   property p_late;
      $rose(wdTimeout) |-> quietCnt_r > WdLimit;
   endproperty
   a_late: assert property (p_late) else $error("timeout too early");
   property p_cap;
      timeoutCapGrounded [*5] |-> !$rose(wdTimeout);
   endproperty
   a_cap: assert property (p_cap) else $error("timeout while disabled");
   property p_wdDis;
      wdTimeout |-> disableState && resetOe || disableState && !$rose(resetOe);
   endproperty
   a_wdDis: assert property (p_wdDis) else $error("timeout not disabling");
   property p_dis;
      disableState && $past(disableState) |-> gateOut == 4'h0;
   endproperty
   a_dis: assert property (p_dis) else $error("gates on while disabled");
   property p_stby;
      standbyActive && $past(standbyActive) |-> gateOut == 4'h0 && !chargePumpRun;
   endproperty
   a_stby: assert property (p_stby) else $error("drive on in standby");
endmodule

// ===== sim/supervisor_watchdog_standby_tb.sv
// Testbench joining the device and host ends
`timescale 1ns/10ps
module supervisor_watchdog_standby_tb;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [15:0] vbatMv = 16'h2EE0;
   logic [15:0] vhostMv = 16'h1388;
   logic [swd_pkg::WD_SET_W-1:0] timeoutSetting = 6'h01;
   logic timeoutCapGrounded = 1'b0;
   logic [3:0] gateCmd = 4'hA;
   logic kickEnable = 1'b1;
   logic standbyReq = 1'b0;
   logic motorStopped = 1'b0;
   logic speedReq = 1'b0;
   logic directionReq = 1'b0;
   logic [3:0] gateOut;
   logic chargePumpRun, disableState, lowSupplyLockout, highSupplyLockout, hostResetHold;
   logic wdTimeout, standbyActive, speedLevel, directionLevel;
   logic hostInReset, standbyGranted, driveReady;
   int err_total = 0;
   int cmp_count = 0;
   int n;
   swd_link_if lnk();
   always #20 clk_sys = ~clk_sys;
   swd_device #(.WdBaseCyc(20), .WdStepCyc(40)) i_swd_device (.clk_sys, .nrst, .link(lnk),
      .vbatMv, .vhostMv, .timeoutSetting, .timeoutCapGrounded, .gateCmd, .gateOut,
      .chargePumpRun, .disableState, .lowSupplyLockout, .highSupplyLockout, .hostResetHold,
      .wdTimeout, .standbyActive, .speedLevel, .directionLevel);
   swd_host #(.KickPeriodCyc(10), .SettleCyc(30)) i_swd_host (.clk_sys, .nrst, .link(lnk),
      .kickEnable, .standbyReq, .motorStopped, .speedReq, .directionReq, .hostInReset,
      .standbyGranted, .driveReady);
   swd_checker #(.WdLimit(60)) i_swd_checker (.clk_sys, .nrst, .kick(lnk.kick),
      .resetDrive(lnk.resetDrive), .resetOe(lnk.resetOe), .resetLine(lnk.resetLine),
      .timeoutCapGrounded, .gateOut, .chargePumpRun, .disableState, .wdTimeout, .standbyActive);
   task automatic cyc(input int c);
      repeat (c) @(posedge clk_sys);
      #1;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chkb(input string nm, input logic e, input logic g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %b got %b", nm, e, g);
      end
   endtask
   task automatic chkv(input string nm, input logic [3:0] e, input logic [3:0] g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   // Bounded wait for the watchdog flag
   task automatic waitWd(input logic e);
      n = 0;
      while (wdTimeout !== e && n < 1000) begin
         cyc(1);
         n++;
      end
      if (n == 1000) begin
         err_total++;
         tally_and_finish;
      end
   endtask
   task automatic t_supply;
      chkv("gates", 4'hA, gateOut);
      vbatMv = 16'h1770;
      cyc(3);
      chkb("uv", 1'b1, lowSupplyLockout);
      chkv("gates", 4'h0, gateOut);
      chkb("dis", 1'b1, disableState);
      vbatMv = 16'h189C;
      cyc(3);
      chkb("uvHys", 1'b1, lowSupplyLockout);
      vbatMv = 16'h5014;
      cyc(3);
      chkb("uv", 1'b0, lowSupplyLockout);
      chkb("ov", 1'b1, highSupplyLockout);
      vbatMv = 16'h4D58;
      cyc(3);
      chkb("ovHys", 1'b1, highSupplyLockout);
      vbatMv = 16'h2EE0;
      vhostMv = 16'h1004;
      cyc(5);
      chkb("ov", 1'b0, highSupplyLockout);
      chkb("hold", 1'b1, hostResetHold);
      chkb("rstLine", 1'b0, lnk.resetLine);
      chkb("hostRst", 1'b1, hostInReset);
      vhostMv = 16'h109A;
      cyc(9);
      chkb("rstHys", 1'b0, lnk.resetLine);
      chkv("gates", 4'h0, gateOut);
      vhostMv = 16'h1388;
      cyc(40);
      chkb("rstLine", 1'b1, lnk.resetLine);
      chkv("gates", 4'hA, gateOut);
      chkb("dis", 1'b0, disableState);
      $display("supply done");
   endtask
   task automatic t_wd;
      int m;
      kickEnable = 1'b0;
      waitWd(1'b1);
      chkb("wdTime", 1'b1, n inside {[50:80]});
      m = 0;
      while (lnk.resetLine === 1'b0 && m < 1000) begin
         cyc(1);
         m++;
      end
      chkb("pulseLen", 1'b1, m == 500);
      if (m == 1000) tally_and_finish;
      cyc(100);
      chkb("oneShot", 1'b1, lnk.resetLine);
      chkb("lock", 1'b1, wdTimeout);
      chkv("gates", 4'h0, gateOut);
      kickEnable = 1'b1;
      waitWd(1'b0);
      cyc(4);
      chkv("gates", 4'hA, gateOut);
      timeoutCapGrounded = 1'b1;
      kickEnable = 1'b0;
      cyc(300);
      chkb("capOff", 1'b0, wdTimeout);
      kickEnable = 1'b1;
      cyc(20);
      timeoutCapGrounded = 1'b0;
      cyc(100);
      chkb("wdRun", 1'b0, wdTimeout);
      timeoutSetting = 6'h02;
      cyc(20);
      kickEnable = 1'b0;
      waitWd(1'b1);
      chkb("wdStep", 1'b1, n inside {[90:110]});
      kickEnable = 1'b1;
      cyc(520);
      waitWd(1'b0);
      timeoutSetting = 6'h01;
      cyc(20);
      $display("watchdog done");
   endtask
   task automatic t_stby;
      standbyReq = 1'b1;
      cyc(8);
      chkb("noGrant", 1'b0, standbyGranted);
      chkb("noStby", 1'b0, standbyActive);
      motorStopped = 1'b1;
      cyc(8);
      chkb("granted", 1'b1, standbyGranted);
      chkb("stby", 1'b1, standbyActive);
      chkb("pump", 1'b0, chargePumpRun);
      chkv("gates", 4'h0, gateOut);
      kickEnable = 1'b0;
      waitWd(1'b1);
      chkb("stbyWd", 1'b0, lnk.resetLine);
      kickEnable = 1'b1;
      cyc(520);
      waitWd(1'b0);
      speedReq = 1'b1;
      directionReq = 1'b1;
      standbyReq = 1'b0;
      cyc(20);
      chkb("settle", 1'b0, speedLevel);
      cyc(40);
      chkb("ready", 1'b1, driveReady);
      chkb("speed", 1'b1, speedLevel);
      chkb("dir", 1'b1, directionLevel);
      chkv("gates", 4'hA, gateOut);
      chkb("pumpOn", 1'b1, chargePumpRun);
      $display("standby done");
   endtask
   initial begin
      cyc(12);
      chkb("rstLow", 1'b0, lnk.resetLine);
      nrst = 1'b1;
      cyc(2);
      chkb("stbyRst", 1'b0, standbyActive);
      cyc(38);
      t_supply;
      t_wd;
      t_stby;
      tally_and_finish;
   end
endmodule
